// file: ebus_consts.vh
// Constants for the external bus cycle and arbitration controller
`ifndef EBUS_CONSTS_VH
`define EBUS_CONSTS_VH

`define ADDR_W 16
`define DATA_W 16
`define CS_W 5
`define WAIT_W 4
`define CLK_PERIOD_NS 40
`define TAIL_NONE_CYC 2'h0
`define TAIL_MUX_CYC 2'h1
`define TAIL_TRI_CYC 2'h2

`endif

// file: in_sync.v
// Two flip-flop synchroniser for external level inputs
`timescale 1ns/100ps
`default_nettype none
module in_sync #(
    parameter RESET_VAL = 1'b1
) (
    input wire clk_sys,
    input wire rst_b,
    input wire d_in,
    output reg q_out
);
    reg meta_reg;

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= RESET_VAL;
            q_out <= RESET_VAL;
        end else begin
            meta_reg <= d_in;
            q_out <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// file: ebus_ctrl.v
// External bus cycle controller with ready wait states and hold arbitration
`timescale 1ns/100ps
`default_nettype none
`include "ebus_consts.vh"
// Function
// - Each cycle runs its programmed length including memory wait states before ready sampling.
// - Command delay option postpones the strobe leading edge by one cycle.
// - Ready sampled high adds a wait state; sampled low ends the cycle.
// - Multiplexed mode adds a mux wait state, plus optional tristate wait state.
// - Next cycle starts only after trailing wait states have elapsed.
// - Hold request finishes the running cycle before the bus is granted.
// - Chip selects are released, not driven high, while the bus is granted.
// - Regain request never asserts before release and grant.
// - Regain sequence starts when hold request goes high, whatever regain did.
// - After regain completes, grant and regain removed, own cycles may start.
// - Read data is captured on the edge that ends the strobe.
module ebus_ctrl (
    input wire clk_sys,
    input wire rst_b,
    input wire req_valid,
    input wire req_write,
    input wire [`ADDR_W-1:0] req_addr,
    input wire [`DATA_W-1:0] req_wdata,
    input wire [`CS_W-1:0] req_cs,
    input wire [`WAIT_W-1:0] memory_cycle_wait_count,
    input wire cmd_delay_en,
    input wire mux_mode,
    input wire tristate_wait_enable,
    input wire want_bus,
    input wire ready_b_pin,
    input wire hold_b_pin,
    input wire [`DATA_W-1:0] data_in,
    output reg req_done,
    output reg [`DATA_W-1:0] rd_data,
    output reg [`ADDR_W-1:0] addr_out,
    output reg addr_oe,
    output reg [`DATA_W-1:0] data_out,
    output reg data_oe,
    output reg rd_b,
    output reg wr_b,
    output reg ctrl_oe,
    output reg [`CS_W-1:0] chip_select_lines_b,
    output reg chip_select_oe,
    output reg bus_grant_out_b,
    output reg regain_request_out_b,
    output reg busy
);
    reg [2:0] state_reg;
    reg [`WAIT_W-1:0] wait_reg;
    reg [1:0] tail_reg;
    reg write_reg;
    wire ready_b_s;
    wire hold_b_s;
    wire cycle_end;
    wire [`CS_W-1:0] cs_drive_b;

    // Controller states
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_ADDR = 3'h1;
    localparam [2:0] ST_CMD = 3'h2;
    localparam [2:0] ST_READY = 3'h3;
    localparam [2:0] ST_TAIL = 3'h4;
    localparam [2:0] ST_HELD = 3'h5;
    localparam [2:0] ST_REGAIN = 3'h6;

    // Ready sampled low in the ready state ends the cycle
    assign cycle_end = (state_reg == ST_READY) && !ready_b_s;

    // Active-low chip select pattern for the request
    genvar gi;
    generate
        for (gi = 0; gi < `CS_W; gi = gi + 1) begin : g_cs
            assign cs_drive_b[gi] = ~req_cs[gi];
        end
    endgenerate

    // Ready and hold pins arrive from outside the clock domain

    in_sync #(.RESET_VAL(1'b1)) u_ready (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .d_in(ready_b_pin),
        .q_out(ready_b_s)
    );

    in_sync #(.RESET_VAL(1'b1)) u_hold (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .d_in(hold_b_pin),
        .q_out(hold_b_s)
    );

    // Tail length after a cycle
    function [1:0] tail_len;
        input mux;
        input tri_en;
        begin
            if (!mux)
                tail_len = `TAIL_NONE_CYC;
            else if (tri_en)
                tail_len = `TAIL_TRI_CYC;
            else
                tail_len = `TAIL_MUX_CYC;
        end
    endfunction

    // Read data latched on the edge that raises the read strobe
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= {`DATA_W{1'b0}};
        end else if (cycle_end && !write_reg) begin
            rd_data <= data_in;
        end
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
            wait_reg <= {`WAIT_W{1'b0}};
            tail_reg <= 2'h0;
            write_reg <= 1'b0;
            req_done <= 1'b0;
            addr_out <= {`ADDR_W{1'b0}};
            addr_oe <= 1'b1;
            data_out <= {`DATA_W{1'b0}};
            data_oe <= 1'b0;
            rd_b <= 1'b1;
            wr_b <= 1'b1;
            ctrl_oe <= 1'b1;
            chip_select_lines_b <= {`CS_W{1'b1}};
            chip_select_oe <= 1'b1;
            bus_grant_out_b <= 1'b1;
            regain_request_out_b <= 1'b1;
            busy <= 1'b0;
        end else begin
            req_done <= 1'b0;
            case (state_reg)
                // Hold is only taken between cycles
                ST_IDLE: begin
                    if (!hold_b_s) begin
                        addr_oe <= 1'b0;
                        data_oe <= 1'b0;
                        ctrl_oe <= 1'b0;
                        chip_select_oe <= 1'b0;
                        bus_grant_out_b <= 1'b0;
                        busy <= 1'b1;
                        state_reg <= ST_HELD;
                    end else if (req_valid) begin
                        addr_out <= req_addr;
                        data_out <= req_wdata;
                        write_reg <= req_write;
                        data_oe <= req_write;
                        chip_select_lines_b <= cs_drive_b;
                        wait_reg <= memory_cycle_wait_count;
                        busy <= 1'b1;
                        state_reg <= cmd_delay_en ? ST_ADDR : ST_CMD;
                    end else begin
                        busy <= 1'b0;
                    end
                end
                ST_ADDR: begin
                    state_reg <= ST_CMD;
                end
                // Wait states count down with the strobe active
                ST_CMD: begin
                    rd_b <= write_reg;
                    wr_b <= ~write_reg;
                    if (wait_reg != {`WAIT_W{1'b0}})
                        wait_reg <= wait_reg - 1'b1;
                    else
                        state_reg <= ST_READY;
                end
                ST_READY: begin
                    if (cycle_end) begin
                        rd_b <= 1'b1;
                        wr_b <= 1'b1;
                        data_oe <= 1'b0;
                        chip_select_lines_b <= {`CS_W{1'b1}};
                        req_done <= 1'b1;
                        tail_reg <= tail_len(mux_mode, tristate_wait_enable);
                        state_reg <= ST_TAIL;
                    end
                end
                ST_TAIL: begin
                    if (tail_reg != 2'h0)
                        tail_reg <= tail_reg - 2'h1;
                    else begin
                        busy <= 1'b0;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_HELD: begin
                    if (hold_b_s) begin
                        regain_request_out_b <= 1'b1;
                        bus_grant_out_b <= 1'b1;
                        state_reg <= ST_REGAIN;
                    end else if (want_bus) begin
                        regain_request_out_b <= 1'b0;
                    end
                end
                // Outputs driven again one edge after the grant ends
                ST_REGAIN: begin
                    addr_oe <= 1'b1;
                    ctrl_oe <= 1'b1;
                    chip_select_oe <= 1'b1;
                    busy <= 1'b0;
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// file: ebus_ctrl_properties.sv
// Checker for bus cycle and arbitration behaviour at the controller ports
`timescale 1ns/100ps
`default_nettype none
module ebus_props (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic req_done,
    input wire logic rd_b,
    input wire logic wr_b,
    input wire logic busy,
    input wire logic cmd_delay_en,
    input wire logic [3:0] memory_cycle_wait_count,
    input wire logic ready_b_pin,
    input wire logic hold_b_pin,
    input wire logic chip_select_oe,
    input wire logic addr_oe,
    input wire logic data_oe,
    input wire logic ctrl_oe,
    input wire logic bus_grant_out_b,
    input wire logic regain_request_out_b
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence s_rd_start;
        $fell(rd_b) && memory_cycle_wait_count == 4'h3;
    endsequence
    sequence s_rd_low;
        !rd_b [*4];
    endsequence
    a_done_ready_seen: assert property (req_done |-> $past(!ready_b_pin, 2)) else $error("done without ready");
    a_done_strobe_off: assert property (req_done |-> rd_b && wr_b) else $error("strobe low at done");
    a_done_one_pulse: assert property (req_done |=> !req_done) else $error("done longer than one cycle");
    a_wait_states_held: assert property (s_rd_start |-> s_rd_low) else $error("strobe too short");
    a_delay_strobe: assert property ($rose(busy) && cmd_delay_en |=> rd_b && wr_b) else $error("strobe early");
    a_grant_between: assert property ($fell(bus_grant_out_b) |-> $past(rd_b && wr_b) && $past(!hold_b_pin, 2))
        else $error("grant mid cycle or unsynced");
    a_grant_floats: assert property (!bus_grant_out_b |-> !(chip_select_oe || addr_oe || data_oe || ctrl_oe))
        else $error("bus driven while granted");
    a_regain_granted: assert property (!regain_request_out_b |-> !bus_grant_out_b) else $error("regain early");
    a_hold_release: assert property ($rose(bus_grant_out_b) |-> $past(hold_b_pin, 2) && regain_request_out_b)
        else $error("bad regain");
endmodule
bind ebus_ctrl ebus_props u_props (.*);
`default_nettype wire

// file: ebus_partner.sv
// Ready-driving memory and hold-requesting master model
`timescale 1ns/100ps
`default_nettype none
module ebus_partner (
    input wire logic clk_sys,
    input wire logic rd_b,
    input wire logic wr_b,
    input wire logic hold_req,
    input wire logic [7:0] lat,
    output logic ready_b_pin,
    output logic hold_b_pin,
    output logic [15:0] data_in
);
    logic [7:0] cnt = 8'h00;
    initial {ready_b_pin, hold_b_pin} = 2'b11;
    // Released bus shows the inverse word
    assign data_in = rd_b ? 16'h5a3c : 16'ha5c3;
    always @(posedge clk_sys) begin
        hold_b_pin <= !hold_req;
        if (rd_b && wr_b) begin
            cnt <= 8'h00;
            ready_b_pin <= 1'b1;
        end else if (cnt == lat) begin
            ready_b_pin <= 1'b0;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule
`default_nettype wire

// file: tb.sv
// Testbench for the external bus controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin fail_count++; $display("mismatch %s exp %h got %h", nm, e, s); end end
`define WAITV(s, v) begin n = 0; do begin @(negedge clk_sys); n++; end while ((s) !== (v) && n < 60); \
    if ((s) !== (v)) begin fail_count++; $display("mismatch wait exp %h got %h", v, s); end end
module tb;
    logic clk_sys = 0, rst_b = 0, req_valid = 0, req_write = 0, cmd_delay_en = 0, mux_mode = 0;
    logic tristate_wait_enable = 0, want_bus = 0, hold_req = 0;
    logic [15:0] req_addr = 16'h0000, req_wdata = 16'h0000, rd_data, addr_out, data_out, data_in;
    logic [4:0] req_cs = 5'h00, chip_select_lines_b;
    logic [3:0] memory_cycle_wait_count = 4'h0;
    logic [7:0] lat = 8'h00;
    logic req_done, addr_oe, data_oe, rd_b, wr_b, ctrl_oe, chip_select_oe, bus_grant_out_b;
    logic regain_request_out_b, busy, ready_b_pin, hold_b_pin;
    integer fail_count = 0, compares = 0, n, k;
    ebus_ctrl uut (.*);
    ebus_partner u_partner (.*);
    always #20 clk_sys = ~clk_sys;
    task automatic finish_test;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic bus_op(input logic wr, input logic [3:0] w, input logic dly, input logic mx, input logic tw,
                          input logic hq);
        @(posedge clk_sys);
        {req_valid, req_write, cmd_delay_en, mux_mode, tristate_wait_enable} <= {1'b1, wr, dly, mx, tw};
        {memory_cycle_wait_count, req_addr, req_wdata, req_cs} <= {w, 16'h1234, 16'hbeef, 5'h04};
        `WAITV(busy, 1'b1)
        `CHK("cs", 5'h1b, chip_select_lines_b)
        `CHK("addr", 16'h1234, addr_out)
        `CHK("data_oe", wr, data_oe)
        if (wr) `CHK("wdata", 16'hbeef, data_out)
        @(posedge clk_sys);
        req_valid <= 1'b0;
        hold_req <= hq;
        `WAITV(req_done, 1'b1)
        `CHK("length", 1'b1, n >= 2 + w + dly)
        `CHK("cs_off", 5'h1f, chip_select_lines_b)
        `CHK("strobes", 2'h3, {rd_b, wr_b})
        if (!wr) `CHK("rd_data", 16'ha5c3, rd_data)
        if (!hq) begin
            `WAITV(busy, 1'b0)
            `CHK("tail", 1 + mx + (mx & tw), n)
        end
    endtask
    task automatic test_read;
        bus_op(0, 4'h0, 0, 0, 1, 0);
        $display("test_read done");
    endtask
    task automatic test_write_slow;
        @(posedge clk_sys);
        lat <= 8'h03;
        bus_op(1, 4'h3, 1, 0, 0, 0);
        bus_op(0, 4'h3, 0, 0, 0, 0);
        lat <= 8'h00;
        $display("test_write_slow done");
    endtask
    task automatic test_mux_tail;
        bus_op(0, 4'h1, 0, 1, 1, 0);
        bus_op(0, 4'h0, 0, 1, 0, 0);
        $display("test_mux_tail done");
    endtask
    task automatic test_hold;
        for (k = 1; k >= 0; k--) begin
            bus_op(0, 4'h0, 0, 0, 0, 1);
            `WAITV(bus_grant_out_b, 1'b0)
            `CHK("grant", 1'b0, bus_grant_out_b)
            `CHK("oe", 1'b0, chip_select_oe | addr_oe | ctrl_oe)
            @(posedge clk_sys);
            want_bus <= k[0];
            repeat (4) @(negedge clk_sys);
            `CHK("regain", ~k[0], regain_request_out_b)
            @(posedge clk_sys);
            hold_req <= 1'b0;
            `WAITV(bus_grant_out_b, 1'b1)
            `CHK("released", 1'b1, bus_grant_out_b & regain_request_out_b)
            @(posedge clk_sys);
            want_bus <= 1'b0;
            `WAITV(busy, 1'b0)
            bus_op(0, 4'h0, 0, 0, 0, 0);
        end
        $display("test_hold done");
    endtask
    initial begin
        #100000;
        fail_count++;
        finish_test;
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        test_read;
        test_write_slow;
        test_mux_tail;
        test_hold;
        finish_test;
    end
endmodule
`default_nettype wire
